// *** src/adc_config_register_bank.sv ***
// Configuration and status register bank of the sigma-delta converter
//
// What this block does
// - Serial bits go LSB first if an order bit is 1, else MSB first.
// - Soft reset defaults all but port config, loop enable, loop control.
// - Power 0 normal, 1 local down, 2 standby with reference on, 3 sleep.
// - Bit 7 of the loop control byte shows the live loop lock state.
// - Loop control bit 6 enables auto band; bits 5:0 hold the multiplier.
// - The interleave bit puts both channels onto the 16-bit output bus when samples are at least two cycles apart.
// - The output-disable bit floats the data outputs.
// - The invert bit drives every data output bit inverted.
// - Two 2-bit drive-strength fields; the low-voltage one defaults to 2.
// - The reference select bit chooses the external reference.
// - Top overrange bit routes loop filter resets to the overrange pin.
// - A 6-bit output rate divider defaults to zero.
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_bank
  import adc_cfg_pkg::*;
#(
  parameter logic [7:0] PART_ID_VALUE = 8'h5A,  // Arbitrary value
  parameter logic [1:0] GRADE_VALUE   = 2'h0    // Arbitrary value
)
(
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [adc_cfg_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [adc_cfg_pkg::DATA_W-1:0] reg_wdata,
  output logic      [adc_cfg_pkg::DATA_W-1:0] reg_rdata,
  output logic                               reg_rd_valid,
  output logic                               bit_order_select,
  input  wire logic                          loop_lock_pin,
  input  wire logic                          loop_reset_event,
  input  wire logic                          overrange_detect,
  output logic                               overrange_pin,
  output logic                               multiplier_loop_enable,
  output logic                               auto_band_enable,
  output logic      [5:0]                    loop_multiplier_field,
  output adc_cfg_pkg::power_state_t          power_state_field,
  output logic                               core_powered_down,
  output logic                               reference_kept_on,
  output logic                               bw_10mhz,
  output logic                               bw_5mhz,
  output logic                               bw_2p5mhz,
  output logic                               output_voltage_standard,
  output logic      [1:0]                    drive_strength_high_v,
  output logic      [1:0]                    drive_strength_low_v,
  output logic                               data_clock_invert,
  output logic                               external_ref_select,
  output logic      [5:0]                    output_rate_divider,
  output logic                               overrange_indicator_mode,
  output logic      [5:0]                    overrange_threshold,
  input  wire logic [adc_cfg_pkg::SAMPLE_W-1:0] sample_a,
  input  wire logic [adc_cfg_pkg::SAMPLE_W-1:0] sample_b,
  input  wire logic                          sample_valid,
  output logic      [adc_cfg_pkg::SAMPLE_W-1:0] data_out,
  output logic                               data_oe,
  output logic                               data_valid,
  output logic                               data_is_b
);

  import adc_cfg_pkg::*;

  logic       lock_meta_r;
  logic       lock_sync_r;
  logic       interleave_r;
  logic       out_disable_r;
  logic       invert_r;
  logic [1:0] format_r;
  logic [1:0] bw_r;
  logic       loop_rst_ind_r;
  logic       soft_rst;
  logic       wr_hit_cfg;
  logic [7:0] rd_nxt;

  // Soft reset is a write to port config with either mirrored bit set
  assign wr_hit_cfg = reg_wr && (reg_addr == ADDR_PORT_CFG);
  assign soft_rst = wr_hit_cfg
                    && (reg_wdata[SOFT_RST_HI] || reg_wdata[SOFT_RST_LO]);

  // Lock pin is asynchronous to clk; two stages before use
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      lock_meta_r <= 1'b0;
      lock_sync_r <= 1'b0;
    end
    else
    begin
      lock_meta_r <= loop_lock_pin;
      lock_sync_r <= lock_meta_r;
    end
  end

  // Port config: survives soft reset; either mirror bit sets the order
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      bit_order_select <= 1'b0;
    else if (wr_hit_cfg)
      bit_order_select <= reg_wdata[BIT_ORDER_HI]
                          | reg_wdata[BIT_ORDER_LO];
  end

  // Loop enable and loop control: untouched by soft reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      multiplier_loop_enable <= 1'b0;
      auto_band_enable <= 1'b0;
      loop_multiplier_field <= MULT_RST;
    end
    else if (reg_wr && reg_addr == ADDR_LOOP_EN)
      multiplier_loop_enable <= reg_wdata[LOOP_EN_POS];
    else if (reg_wr && reg_addr == ADDR_LOOP_CTRL)
    begin
      auto_band_enable <= reg_wdata[AUTO_BAND_POS];
      loop_multiplier_field <= reg_wdata[5:0];
    end
  end

  // Power, bandwidth and reference; soft reset returns defaults
  always_ff @(posedge clk)
  begin
    if (sys_rst || soft_rst)
    begin
      power_state_field <= power_state_t'(POWER_RST);
      bw_r <= BW_RST;
      external_ref_select <= 1'b0;
    end
    else if (reg_wr && reg_addr == ADDR_POWER)
      power_state_field <= power_state_t'(reg_wdata[1:0]);
    else if (reg_wr && reg_addr == ADDR_BANDWIDTH)
      bw_r <= reg_wdata[BW_POS+1:BW_POS];
    else if (reg_wr && reg_addr == ADDR_REF)
      external_ref_select <= reg_wdata[EXT_REF_POS];
  end

  // Output stage settings; soft reset returns defaults
  always_ff @(posedge clk)
  begin
    if (sys_rst || soft_rst)
    begin
      output_voltage_standard <= 1'b0;
      interleave_r <= 1'b0;
      out_disable_r <= 1'b0;
      invert_r <= 1'b0;
      format_r <= FMT_RST;
      drive_strength_high_v <= DRV_HIGH_RST;
      drive_strength_low_v <= DRV_LOW_RST;
      data_clock_invert <= 1'b0;
    end
    else if (reg_wr && reg_addr == ADDR_OUT_MODE)
    begin
      output_voltage_standard <= reg_wdata[VSTD_POS];
      interleave_r <= reg_wdata[ILV_POS];
      out_disable_r <= reg_wdata[DIS_POS];
      invert_r <= reg_wdata[INV_POS];
      format_r <= reg_wdata[1:0];
    end
    else if (reg_wr && reg_addr == ADDR_DRIVE)
    begin
      drive_strength_high_v <= reg_wdata[DRV_HIGH_POS+1:DRV_HIGH_POS];
      drive_strength_low_v <= reg_wdata[1:0];
    end
    else if (reg_wr && reg_addr == ADDR_OUT_CLOCK)
      data_clock_invert <= reg_wdata[CLK_INV_POS];
  end

  // Rate divider and overrange controls; soft reset returns defaults
  always_ff @(posedge clk)
  begin
    if (sys_rst || soft_rst)
    begin
      output_rate_divider <= RATE_DIV_RST;
      loop_rst_ind_r <= 1'b0;
      overrange_indicator_mode <= 1'b0;
      overrange_threshold <= OR_THRESH_RST;
    end
    else if (reg_wr && reg_addr == ADDR_RATE_DIV)
      output_rate_divider <= reg_wdata[5:0];
    else if (reg_wr && reg_addr == ADDR_OVERRANGE)
    begin
      loop_rst_ind_r <= reg_wdata[LOOP_RST_IND_POS];
      overrange_indicator_mode <= reg_wdata[OR_MODE_POS];
      overrange_threshold <= reg_wdata[5:0];
    end
  end

  // Decoded power and bandwidth controls, one cycle behind the fields
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      core_powered_down <= 1'b0;
      reference_kept_on <= 1'b1;
      bw_10mhz <= 1'b1;
      bw_5mhz <= 1'b0;
      bw_2p5mhz <= 1'b0;
    end
    else
    begin
      core_powered_down <= power_state_field != PWR_NORMAL;
      reference_kept_on <= power_state_field == PWR_NORMAL
                           || power_state_field == PWR_STANDBY;
      bw_10mhz <= bw_r == BW_10M || bw_r == BW_10M_ALT;
      bw_5mhz <= bw_r == BW_5M;
      bw_2p5mhz <= bw_r == BW_2M5;
    end
  end

  // Overrange pin also carries loop resets when the indicator is on
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      overrange_pin <= 1'b0;
    else
      overrange_pin <= overrange_detect
                       || (loop_rst_ind_r && loop_reset_event);
  end

  // Read mux; unmapped addresses read as zero
  always_comb
  begin
    rd_nxt = 8'h00;
    unique case (reg_addr)
      ADDR_PORT_CFG:  rd_nxt = {1'b0, bit_order_select, 1'b0, 1'b1, 1'b1,
                                1'b0, bit_order_select, 1'b0};
      ADDR_PART_ID:   rd_nxt = PART_ID_VALUE;
      ADDR_GRADE:     rd_nxt = {2'h0, GRADE_VALUE, 4'h0};
      ADDR_POWER:     rd_nxt = {6'h00, power_state_field};
      ADDR_LOOP_EN:   rd_nxt = {5'h00, multiplier_loop_enable, 2'h0};
      ADDR_LOOP_CTRL: rd_nxt = {lock_sync_r, auto_band_enable,
                                loop_multiplier_field};
      ADDR_BANDWIDTH: rd_nxt = {1'b0, bw_r, 5'h00};
      ADDR_OUT_MODE:  rd_nxt = {output_voltage_standard, 1'b0, interleave_r,
                                out_disable_r, 1'b0, invert_r, format_r};
      ADDR_DRIVE:     rd_nxt = {4'h0, drive_strength_high_v,
                                drive_strength_low_v};
      ADDR_OUT_CLOCK: rd_nxt = {data_clock_invert, 7'h00};
      ADDR_REF:       rd_nxt = {1'b0, external_ref_select, 6'h00};
      ADDR_RATE_DIV:  rd_nxt = {2'h0, output_rate_divider};
      ADDR_OVERRANGE: rd_nxt = {loop_rst_ind_r, overrange_indicator_mode,
                                overrange_threshold};
      default:        rd_nxt = 8'h00;
    endcase
  end

  // Read data registered; held until the next read
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      reg_rdata <= 8'h00;
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      reg_rd_valid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rd_nxt;
    end
  end

  // Sample encoding and pin drive
  sample_formatter #(
    .W (SAMPLE_W)
  ) u_fmt (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .sample_a     (sample_a),
    .sample_b     (sample_b),
    .sample_valid (sample_valid),
    .format_sel   (format_r),
    .invert       (invert_r),
    .interleave   (interleave_r),
    .out_disable  (out_disable_r),
    .data_out     (data_out),
    .data_oe      (data_oe),
    .data_valid   (data_valid),
    .data_is_b    (data_is_b)
  );

  property p_order_mirror;
    @(posedge clk) disable iff (sys_rst)
      wr_hit_cfg |=> bit_order_select
        == ($past(reg_wdata[6]) | $past(reg_wdata[1]));
  endproperty
  a_order_mirror: assert property (p_order_mirror)
    else $error("bit order not taken from config write");

  property p_soft_rst_keeps;
    @(posedge clk) disable iff (sys_rst)
      soft_rst |=> $stable(multiplier_loop_enable)
        && $stable(loop_multiplier_field) && power_state_field == PWR_NORMAL
        && drive_strength_low_v == DRV_LOW_RST && output_rate_divider == 6'h00;
  endproperty
  a_soft_rst_keeps: assert property (p_soft_rst_keeps)
    else $error("soft reset touched wrong registers");

  property p_power_decode;
    @(posedge clk) disable iff (sys_rst)
      power_state_field == PWR_STANDBY ##1 power_state_field == PWR_STANDBY
        |-> core_powered_down && reference_kept_on;
  endproperty
  a_power_decode: assert property (p_power_decode)
    else $error("standby decode wrong");

  property p_lock_read;
    @(posedge clk) disable iff (sys_rst)
      (reg_rd && reg_addr == ADDR_LOOP_CTRL)
        |=> reg_rd_valid && reg_rdata[LOCK_POS] == $past(lock_sync_r);
  endproperty
  a_lock_read: assert property (p_lock_read)
    else $error("lock flag not read back");

  property p_lock_track;
    @(posedge clk) disable iff (sys_rst)
      loop_lock_pin [*3] |-> lock_sync_r;
  endproperty
  a_lock_track: assert property (p_lock_track)
    else $error("lock sync stalled");

  property p_bw_decode;
    @(posedge clk) disable iff (sys_rst)
      bw_r == BW_2M5 |=> bw_2p5mhz && !bw_10mhz && !bw_5mhz;
  endproperty
  a_bw_decode: assert property (p_bw_decode)
    else $error("bandwidth decode wrong");

  property p_loop_reset_pin;
    @(posedge clk) disable iff (sys_rst)
      (loop_rst_ind_r && loop_reset_event) |=> overrange_pin;
  endproperty
  a_loop_reset_pin: assert property (p_loop_reset_pin)
    else $error("loop reset not shown on overrange pin");

  property p_loop_reset_quiet;
    @(posedge clk) disable iff (sys_rst)
      (!loop_rst_ind_r && !overrange_detect) |=> !overrange_pin;
  endproperty
  a_loop_reset_quiet: assert property (p_loop_reset_quiet)
    else $error("overrange pin set without cause");

endmodule
`default_nettype wire

// *** shared/adc_cfg_pkg.sv ***
// Constants shared by the converter configuration register bank
package adc_cfg_pkg;

  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int SAMPLE_W = 16;

  // Register byte addresses
  localparam logic [12:0] ADDR_PORT_CFG  = 13'h0000;
  localparam logic [12:0] ADDR_PART_ID   = 13'h0001;
  localparam logic [12:0] ADDR_GRADE     = 13'h0002;
  localparam logic [12:0] ADDR_POWER     = 13'h0008;
  localparam logic [12:0] ADDR_LOOP_EN   = 13'h0009;
  localparam logic [12:0] ADDR_LOOP_CTRL = 13'h000A;
  localparam logic [12:0] ADDR_BANDWIDTH = 13'h000F;
  localparam logic [12:0] ADDR_OUT_MODE  = 13'h0014;
  localparam logic [12:0] ADDR_DRIVE     = 13'h0015;
  localparam logic [12:0] ADDR_OUT_CLOCK = 13'h0016;
  localparam logic [12:0] ADDR_REF       = 13'h0018;
  localparam logic [12:0] ADDR_RATE_DIV  = 13'h0101;
  localparam logic [12:0] ADDR_OVERRANGE = 13'h0111;

  // Field positions
  localparam int BIT_ORDER_HI = 6;
  localparam int BIT_ORDER_LO = 1;
  localparam int SOFT_RST_HI = 5;
  localparam int SOFT_RST_LO = 2;
  localparam int CFG_FIXED_HI = 4;
  localparam int CFG_FIXED_LO = 3;
  localparam int GRADE_POS = 4;
  localparam int LOOP_EN_POS = 2;
  localparam int LOCK_POS = 7;
  localparam int AUTO_BAND_POS = 6;
  localparam int BW_POS = 5;
  localparam int VSTD_POS = 7;
  localparam int ILV_POS = 5;
  localparam int DIS_POS = 4;
  localparam int INV_POS = 2;
  localparam int DRV_HIGH_POS = 2;
  localparam int CLK_INV_POS = 7;
  localparam int EXT_REF_POS = 6;
  localparam int LOOP_RST_IND_POS = 7;
  localparam int OR_MODE_POS = 6;

  // Values after reset
  localparam logic [1:0] POWER_RST = 2'h0;
  localparam logic [5:0] MULT_RST = 6'h00;
  localparam logic [1:0] BW_RST = 2'h0;
  localparam logic [1:0] FMT_RST = 2'h0;
  localparam logic [1:0] DRV_HIGH_RST = 2'h0;
  localparam logic [1:0] DRV_LOW_RST = 2'h2;
  localparam logic [5:0] RATE_DIV_RST = 6'h00;
  localparam logic [5:0] OR_THRESH_RST = 6'h00;

  // Output sample encodings
  localparam logic [1:0] FMT_OFFSET = 2'h0;
  localparam logic [1:0] FMT_TWOS = 2'h1;
  localparam logic [1:0] FMT_GRAY = 2'h2;
  localparam logic [1:0] FMT_OFFSET_ALT = 2'h3;

  // Bandwidth codes
  localparam logic [1:0] BW_10M = 2'h0;
  localparam logic [1:0] BW_5M = 2'h1;
  localparam logic [1:0] BW_2M5 = 2'h2;
  localparam logic [1:0] BW_10M_ALT = 2'h3;

  typedef enum logic [1:0] {
    PWR_NORMAL,
    PWR_LOCAL_DOWN,
    PWR_STANDBY,
    PWR_SLEEP
  } power_state_t;

endpackage

// *** src/sample_formatter.sv ***
// Output sample encoder: format, inversion, interleave and tristate
`timescale 1ns/1ps
`default_nettype none
module sample_formatter
  import adc_cfg_pkg::*;
#(
  parameter int W = adc_cfg_pkg::SAMPLE_W
)
(
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] sample_a,
  input  wire logic [W-1:0] sample_b,
  input  wire logic         sample_valid,
  input  wire logic [1:0]   format_sel,
  input  wire logic         invert,
  input  wire logic         interleave,
  input  wire logic         out_disable,
  output logic      [W-1:0] data_out,
  output logic              data_oe,
  output logic              data_valid,
  output logic              data_is_b
);

  logic [W-1:0] pend_b_r;
  logic         pend_r;

  // Samples arrive as twos complement; re-encode for the pins
  function automatic logic [W-1:0] encode(input logic [W-1:0] s,
                                          input logic [1:0] f,
                                          input logic inv);
    logic [W-1:0] ob;
    logic [W-1:0] r;
    ob = {~s[W-1], s[W-2:0]};
    unique case (f)
      FMT_TWOS:   r = s;
      FMT_GRAY:   r = ob ^ (ob >> 1);
      default:    r = ob;
    endcase
    return inv ? ~r : r;
  endfunction

  // Second channel waits one cycle behind the first when interleaving
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pend_r <= 1'b0;
      pend_b_r <= '0;
    end
    else
    begin
      pend_r <= sample_valid && interleave;
      if (sample_valid)
        pend_b_r <= sample_b;
    end
  end

  // Registered pin drive; new samples outrank a pending one
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      data_out <= '0;
      data_valid <= 1'b0;
      data_is_b <= 1'b0;
    end
    else if (sample_valid)
    begin
      data_out <= encode(sample_a, format_sel, invert);
      data_valid <= 1'b1;
      data_is_b <= 1'b0;
    end
    else if (pend_r)
    begin
      data_out <= encode(pend_b_r, format_sel, invert);
      data_valid <= 1'b1;
      data_is_b <= 1'b1;
    end
    else
    begin
      data_valid <= 1'b0;
      data_is_b <= 1'b0;
    end
  end

  // Enable low means the pins float
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      data_oe <= 1'b0;
    else
      data_oe <= ~out_disable;
  end

  property p_oe_follows_disable;
    @(posedge clk) disable iff (sys_rst)
      out_disable |=> !data_oe;
  endproperty
  a_oe_follows_disable: assert property (p_oe_follows_disable)
    else $error("data outputs driven while disabled");

  property p_invert_twos;
    @(posedge clk) disable iff (sys_rst)
      (sample_valid && invert && format_sel == FMT_TWOS)
        |=> data_out == ~$past(sample_a);
  endproperty
  a_invert_twos: assert property (p_invert_twos)
    else $error("inverted sample mismatch");

  property p_offset_binary;
    @(posedge clk) disable iff (sys_rst)
      (sample_valid && !invert && (format_sel == FMT_OFFSET
        || format_sel == FMT_OFFSET_ALT))
        |=> data_out == ($past(sample_a) ^ {1'b1, {(W-1){1'b0}}});
  endproperty
  a_offset_binary: assert property (p_offset_binary)
    else $error("offset binary encoding wrong");

  property p_interleave_b;
    @(posedge clk) disable iff (sys_rst)
      (sample_valid && interleave) ##1 !sample_valid
        |=> data_is_b && data_valid;
  endproperty
  a_interleave_b: assert property (p_interleave_b)
    else $error("second channel missing after first");

endmodule
`default_nettype wire

// *** bench/cfg_master.sv ***
// Byte-wide configuration master standing in for the serial framer
`timescale 1ns/1ps
`default_nettype none
module cfg_master
(
  input  wire logic        clk,
  input  wire logic [7:0]  reg_rdata,
  input  wire logic        reg_rd_valid,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [12:0] reg_addr,
  output logic      [7:0]  reg_wdata
);
  // Idle bus shows inverted leftovers, never a stale copy
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 13'h1FFF;
    reg_wdata = 8'hFF;
  end

  // One byte write, strobe held across exactly one rising edge
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // One byte read; valid stands one cycle, so it is taken mid-cycle
  task automatic rd(input logic [12:0] a, output logic [7:0] d,
                    output logic ok);
    int n;
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    ok = 1'b0;
    d = 8'h00;
    n = 0;
    // Bounded so a silent design cannot hang the run
    while (!ok && n < 4)
    begin
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      ok = (reg_rd_valid === 1'b1);
      d = reg_rdata;
      n++;
    end
  endtask
endmodule
`default_nettype wire

// *** bench/adc_config_register_bank_tb_top.sv ***
// Self-checking bench for the converter configuration register bank
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_bank_tb_top;
  import adc_cfg_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr, reg_rd, reg_rd_valid, bit_order_select;
  logic [12:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic loop_lock_pin = 1'b0;
  logic loop_reset_event = 1'b0;
  logic overrange_detect = 1'b0;
  logic sample_valid = 1'b0;
  logic [15:0] sample_a = 16'h0000;
  logic [15:0] sample_b = 16'h0000;
  logic overrange_pin, multiplier_loop_enable, auto_band_enable;
  logic [5:0] loop_multiplier_field, output_rate_divider;
  logic [5:0] overrange_threshold;
  power_state_t power_state_field;
  logic core_powered_down, reference_kept_on, bw_10mhz, bw_5mhz;
  logic bw_2p5mhz, output_voltage_standard, data_clock_invert;
  logic external_ref_select, overrange_indicator_mode;
  logic [1:0] drive_strength_high_v, drive_strength_low_v;
  logic [15:0] data_out;
  logic data_oe, data_valid, data_is_b;
  int errors = 0;
  int total_checks = 0;

  always #10 clk = ~clk;

  adc_config_register_bank adc_config_register_bank_inst (.clk, .sys_rst,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid,
    .bit_order_select, .loop_lock_pin, .loop_reset_event,
    .overrange_detect, .overrange_pin, .multiplier_loop_enable,
    .auto_band_enable, .loop_multiplier_field, .power_state_field,
    .core_powered_down, .reference_kept_on, .bw_10mhz, .bw_5mhz,
    .bw_2p5mhz, .output_voltage_standard, .drive_strength_high_v,
    .drive_strength_low_v, .data_clock_invert, .external_ref_select,
    .output_rate_divider, .overrange_indicator_mode, .overrange_threshold,
    .sample_a, .sample_b, .sample_valid, .data_out, .data_oe, .data_valid,
    .data_is_b);

  cfg_master cfg_master_inst (.clk, .reg_rdata, .reg_rd_valid, .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata);

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("FAIL %0t got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask

  // Write, then let decoded outputs settle
  task automatic w(input logic [12:0] a, input logic [7:0] d);
    cfg_master_inst.wr(a, d);
    repeat (3) @(negedge clk);
  endtask

  task automatic rc(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    cfg_master_inst.rd(a, d, ok);
    if (!ok)
    begin
      $display("FAIL %0t read answer missing", $time);
      errors++;
      stop_test();
    end
    else
      chk({8'h00, d}, {8'h00, e});
  endtask

  // Offset binary flips the sign bit; Gray is built on offset binary
  function automatic logic [15:0] enc(input logic [15:0] s,
                                      input logic [2:0] m);
    logic [15:0] ob;
    logic [15:0] r;
    ob = s ^ 16'h8000;
    r = (m[1:0] == 2'h1) ? s : (m[1:0] == 2'h2) ? (ob ^ (ob >> 1)) : ob;
    return m[2] ? ~r : r;
  endfunction

  // One sample in; channel b checked in the following cycle if interleaved
  task automatic smp(input logic [15:0] a, input logic [15:0] b,
                     input logic [7:0] m);
    @(negedge clk);
    sample_a = a;
    sample_b = b;
    sample_valid = 1'b1;
    @(negedge clk);
    sample_valid = 1'b0;
    chk(data_valid, 16'h0001);
    chk(data_is_b, 16'h0000);
    chk(data_out, enc(a, m[2:0]));
    if (m[5])
    begin
      @(negedge clk);
      chk(data_is_b, 16'h0001);
      chk(data_out, enc(b, m[2:0]));
    end
  endtask

  // Watchdog against a hung run
  initial
  begin
    repeat (5000) @(posedge clk);
    $display("FAIL %0t run exceeded its cycle budget", $time);
    errors++;
    stop_test();
  end

  initial
  begin
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    rc(ADDR_PORT_CFG, 8'h18);
    rc(ADDR_POWER, 8'h00);
    rc(ADDR_LOOP_CTRL, 8'h00);
    rc(ADDR_DRIVE, 8'h02);
    rc(ADDR_RATE_DIV, 8'h00);
    rc(ADDR_OVERRANGE, 8'h00);
    rc(13'h0003, 8'h00);
    w(ADDR_PART_ID, 8'hA5);
    rc(ADDR_PART_ID, 8'h5A);
    rc(ADDR_GRADE, 8'h00);
    $display("defaults done");
    w(ADDR_PORT_CFG, 8'h40);
    chk(bit_order_select, 16'h0001);
    rc(ADDR_PORT_CFG, 8'h5A);
    w(ADDR_PORT_CFG, 8'h02);
    chk(bit_order_select, 16'h0001);
    w(ADDR_PORT_CFG, 8'h00);
    chk(bit_order_select, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      w(ADDR_POWER, 8'(i));
      chk(power_state_field, 16'(i));
      chk(core_powered_down, 16'(i != 0));
      chk(reference_kept_on, 16'(i == 0 || i == 2));
      w(ADDR_BANDWIDTH, 8'(i << 5));
      chk({bw_10mhz, bw_5mhz, bw_2p5mhz},
          (i == 1) ? 16'h0002 : (i == 2) ? 16'h0001 : 16'h0004);
    end
    $display("modes done");
    w(ADDR_LOOP_EN, 8'h04);
    w(ADDR_LOOP_CTRL, 8'hFF);
    chk({auto_band_enable, loop_multiplier_field}, 16'h007F);
    rc(ADDR_LOOP_CTRL, 8'h7F);
    loop_lock_pin = 1'b1;
    repeat (4) @(negedge clk);
    rc(ADDR_LOOP_CTRL, 8'hFF);
    $display("loop done");
    w(ADDR_DRIVE, 8'h0D);
    chk({drive_strength_high_v, drive_strength_low_v}, 16'h000D);
    w(ADDR_REF, 8'h40);
    chk(external_ref_select, 16'h0001);
    w(ADDR_OUT_CLOCK, 8'h80);
    chk(data_clock_invert, 16'h0001);
    rc(ADDR_OUT_CLOCK, 8'h80);
    w(ADDR_RATE_DIV, 8'h2A);
    chk(output_rate_divider, 16'h002A);
    w(ADDR_PORT_CFG, 8'h60);
    chk(external_ref_select, 16'h0000);
    chk(output_rate_divider, 16'h0000);
    chk(data_clock_invert, 16'h0000);
    chk(multiplier_loop_enable, 16'h0001);
    rc(ADDR_DRIVE, 8'h02);
    rc(ADDR_LOOP_CTRL, 8'hFF);
    rc(ADDR_PORT_CFG, 8'h5A);
    w(ADDR_REF, 8'h40);
    w(ADDR_PORT_CFG, 8'h04);
    chk(external_ref_select, 16'h0000);
    $display("soft reset done");
    for (int f = 0; f < 4; f++)
    begin
      w(ADDR_OUT_MODE, 8'(f));
      smp(16'h0001 + 16'(f * 16'h1234), 16'h0000, 8'(f));
    end
    w(ADDR_OUT_MODE, 8'h06);
    smp(16'hC3A5, 16'h0000, 8'h06);
    w(ADDR_OUT_MODE, 8'h05);
    smp(16'h1234, 16'h0000, 8'h05);
    w(ADDR_OUT_MODE, 8'h21);
    smp(16'h7FFF, 16'h8000, 8'h21);
    chk(data_oe, 16'h0001);
    w(ADDR_OUT_MODE, 8'h10);
    chk(data_oe, 16'h0000);
    w(ADDR_OUT_MODE, 8'h80);
    chk(output_voltage_standard, 16'h0001);
    chk(data_oe, 16'h0001);
    $display("samples done");
    w(ADDR_OVERRANGE, 8'hC5);
    chk({overrange_indicator_mode, overrange_threshold}, 16'h0045);
    rc(ADDR_OVERRANGE, 8'hC5);
    loop_reset_event = 1'b1;
    repeat (2) @(negedge clk);
    chk(overrange_pin, 16'h0001);
    w(ADDR_OVERRANGE, 8'h00);
    chk(overrange_pin, 16'h0000);
    overrange_detect = 1'b1;
    repeat (2) @(negedge clk);
    chk(overrange_pin, 16'h0001);
    $display("overrange done");
    stop_test();
  end
endmodule
`default_nettype wire
